// *** verilog/cpcr_regs.sv ***
// codec power and clock control register bank with decoded outputs
// How it works
// - oversample bit 0 gives 64x, 1 gives 128x
// - source select and master clock halving bits
// - 256 family ratio codes 0-9, rest reserved
// - 272 family ratio codes 0-9, rest reserved
// - 250 family ratio codes 0-9, rest reserved
// - ratio field bits 13:10, resets to 0011
// - dac buffer bias codes 1, 0.5, 0.66, 0.75
// - input amp enables bits 1 and 0
// - output mixer enables bits 1 and 0
// - headphone enables bits 1 and 0
// - line output enables bits 1 and 0
// - speaker mixer enables bits 1 and 0
// - speaker output enables bits 1 and 0
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module cpcr_regs #(
  parameter int RATIO_W = 11
) (
  input wire logic clk,
  input wire logic rst,
  input cpcr_pkg::cpcr_bus_req_t busReq,
  output logic [15:0] rdata,
  input cpcr_pkg::cpcr_family_t sysclkFamilySelect,
  output cpcr_pkg::cpcr_power_t powerOn,
  output logic [1:0] dacRefBufferBias,
  output logic [6:0] dacBiasPercent,
  output logic adcHighPerfOversample,
  output logic [7:0] adcOversampleRatio,
  output logic sysclkSourceSelect,
  output logic masterClockHalve,
  output logic [3:0] sysclkFsRatio,
  output logic [RATIO_W-1:0] sysclkRatioValue,
  output logic sysclkRatioReserved,
  output logic oversampleUnsupported
);

  // refuse a ratio port too narrow for the largest table entry
  if (RATIO_W < cpcr_pkg::RATIO_W) begin : g_bad_width
    $error("ratio width too small for largest ratio");
  end

  // ---------------------------------------------------------------
  // register storage

  // view of every register as it reads back
  logic [15:0] regQ [cpcr_pkg::NREG];

  // address hit per register
  logic [cpcr_pkg::NREG-1:0] hit;

  // read data accumulated along the register chain
  logic [15:0] rdChain [cpcr_pkg::NREG+1];

  // status word built from decoded state
  logic [15:0] statusWord;

  assign rdChain[0] = 16'h0000;

  genvar gi;
  generate
    for (gi = 0; gi < cpcr_pkg::NREG; gi++) begin : g_reg
      // decode of this register's offset
      assign hit[gi] = (busReq.addr == cpcr_pkg::REG_OFS[gi]);

      if (gi == cpcr_pkg::IX_STATUS) begin : g_ro
        // status is read only; writes are dropped
        assign regQ[gi] = statusWord;
      end else begin : g_rw
        logic [15:0] q;
        wire doWrite = busReq.wr && hit[gi];
        // only the listed bits can be written
        wire [15:0] next_q = busReq.wdata & cpcr_pkg::REG_MASK[gi];

        // hold until rewritten or reset
        always_ff @(posedge clk) begin
          if (rst) begin
            q <= cpcr_pkg::REG_RST[gi];
          end else if (doWrite) begin
            q <= next_q;
          end
        end

        assign regQ[gi] = q;
      end

      // unselected registers contribute zero to the read value
      assign rdChain[gi+1] = rdChain[gi] | (hit[gi] ? regQ[gi] : 16'h0000);
    end
  endgenerate

  // ---------------------------------------------------------------
  // read port

  // read value, zero for unmapped addresses
  wire [15:0] rdValue = rdChain[cpcr_pkg::NREG];

  // data appear the cycle after the strobe and only then
  wire [15:0] next_rdata = busReq.rd ? rdValue : 16'h0000;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // field extraction

  // dac buffer bias field
  wire [1:0] biasField = regQ[cpcr_pkg::IX_DAC_BIAS][cpcr_pkg::BIAS_LSB +: 2];

  // adc oversampling bit
  wire osrField = regQ[cpcr_pkg::IX_ADC_OSR][cpcr_pkg::OSR_BIT];

  // clock source and halving bits
  wire halveField = regQ[cpcr_pkg::IX_CLK_DIV][cpcr_pkg::HALVE_BIT];
  wire srcField = regQ[cpcr_pkg::IX_CLK_RATES][cpcr_pkg::SRC_BIT];

  // ratio code field
  wire [3:0] rateField = regQ[cpcr_pkg::IX_CLK_RATES][cpcr_pkg::RATE_LSB +: 4];

  // converter power field
  wire [3:0] convField = regQ[cpcr_pkg::IX_CONVERTER][3:0];

  // left/right enable pairs, left at bit 1 and right at bit 0
  wire [1:0] pairField [cpcr_pkg::NPAIR];

  generate
    for (gi = 0; gi < cpcr_pkg::NPAIR; gi++) begin : g_pair
      assign pairField[gi] = regQ[cpcr_pkg::IX_PAIR_FIRST + gi][1:0];
    end
  endgenerate

  // ---------------------------------------------------------------
  // decoded values

  // oversampling ratio for the adc
  wire [7:0] osrValue = osrField ? cpcr_pkg::OSR_HIGH : cpcr_pkg::OSR_LOW;

  // bias as a percentage of normal
  wire [6:0] biasValue = cpcr_pkg::BIAS_PCT[biasField];

  // low-power oversampling is not usable with 250 family clocks
  wire next_unsupported = !osrField && (sysclkFamilySelect == cpcr_pkg::CPCR_FAM_250);

  // ratio lookup for the current family and code
  logic [RATIO_W-1:0] ratioLookup;
  logic ratioRsvdLookup;

  cpcr_ratio_decode #(
    .RATIO_W(RATIO_W)
  ) u_ratio (
    .family(sysclkFamilySelect),
    .code(rateField),
    .ratio(ratioLookup),
    .reserved(ratioRsvdLookup)
  );

  // status word: ratio, reserved flag, unsupported flag, family
  always_comb begin
    statusWord = 16'h0000;
    statusWord[cpcr_pkg::RATIO_W-1:0] = sysclkRatioValue[cpcr_pkg::RATIO_W-1:0];
    statusWord[cpcr_pkg::ST_RSVD_BIT] = sysclkRatioReserved;
    statusWord[cpcr_pkg::ST_UNSUP_BIT] = oversampleUnsupported;
    statusWord[cpcr_pkg::ST_FAM_LSB +: 2] = sysclkFamilySelect;
  end

  // ---------------------------------------------------------------
  // power enable outputs

  // analog enables follow the register bits one cycle later
  always_ff @(posedge clk) begin
    if (rst) begin
      powerOn <= '0;
    end else begin
      powerOn.inputAmp <= pairField[0];
      powerOn.outMixer <= pairField[1];
      powerOn.headphone <= pairField[2];
      powerOn.lineOut <= pairField[3];
      powerOn.spkMixer <= pairField[4];
      powerOn.spkOut <= pairField[5];
      powerOn.dac <= convField[3:2];
      powerOn.adc <= convField[1:0];
    end
  end

  // ---------------------------------------------------------------
  // dac bias outputs

  // raw code and its decoded strength
  always_ff @(posedge clk) begin
    if (rst) begin
      dacRefBufferBias <= 2'b00;
      dacBiasPercent <= cpcr_pkg::BIAS_PCT[0];
    end else begin
      dacRefBufferBias <= biasField;
      dacBiasPercent <= biasValue;
    end
  end

  // ---------------------------------------------------------------
  // adc oversampling outputs

  // mode bit, ratio and the unsupported-combination warning
  always_ff @(posedge clk) begin
    if (rst) begin
      adcHighPerfOversample <= 1'b1;
      adcOversampleRatio <= cpcr_pkg::OSR_HIGH;
      oversampleUnsupported <= 1'b0;
    end else begin
      adcHighPerfOversample <= osrField;
      adcOversampleRatio <= osrValue;
      oversampleUnsupported <= next_unsupported;
    end
  end

  // ---------------------------------------------------------------
  // system clock control outputs

  // source select and master clock halving go to the clock tree
  always_ff @(posedge clk) begin
    if (rst) begin
      sysclkSourceSelect <= 1'b0;
      masterClockHalve <= 1'b0;
    end else begin
      sysclkSourceSelect <= srcField;
      masterClockHalve <= halveField;
    end
  end

  // ---------------------------------------------------------------
  // ratio outputs

  // code, decoded ratio and reserved flag for the clock generator
  always_ff @(posedge clk) begin
    if (rst) begin
      sysclkFsRatio <= 4'h3;
      sysclkRatioValue <= '0;
      sysclkRatioReserved <= 1'b0;
    end else begin
      sysclkFsRatio <= rateField;
      sysclkRatioValue <= ratioLookup;
      sysclkRatioReserved <= ratioRsvdLookup;
    end
  end

endmodule // cpcr_regs

// *** verilog/cpcr_pkg.sv ***
// constants, types and lookup tables for the codec power and clock register bank
package cpcr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NREG = 12;

  // register offsets, index order matches the tables below
  localparam logic [7:0] OFS_DAC_BIAS = 8'h08;
  localparam logic [7:0] OFS_ADC_OSR = 8'h0A;
  localparam logic [7:0] OFS_INPUT_AMP = 8'h0C;
  localparam logic [7:0] OFS_OUT_MIXER = 8'h0D;
  localparam logic [7:0] OFS_HEADPHONE = 8'h0E;
  localparam logic [7:0] OFS_LINE_OUT = 8'h0F;
  localparam logic [7:0] OFS_SPK_MIXER = 8'h10;
  localparam logic [7:0] OFS_SPK_OUT = 8'h11;
  localparam logic [7:0] OFS_CONVERTER = 8'h12;
  localparam logic [7:0] OFS_CLK_DIV = 8'h14;
  localparam logic [7:0] OFS_CLK_RATES = 8'h15;
  localparam logic [7:0] OFS_STATUS = 8'h1F;

  localparam logic [7:0] REG_OFS [NREG] = '{OFS_DAC_BIAS, OFS_ADC_OSR, OFS_INPUT_AMP,
    OFS_OUT_MIXER, OFS_HEADPHONE, OFS_LINE_OUT, OFS_SPK_MIXER, OFS_SPK_OUT,
    OFS_CONVERTER, OFS_CLK_DIV, OFS_CLK_RATES, OFS_STATUS};
  // writable bits of each register; status is read only
  localparam logic [15:0] REG_MASK [NREG] = '{16'h0006, 16'h0001, 16'h0003, 16'h0003,
    16'h0003, 16'h0003, 16'h0003, 16'h0003, 16'h000F, 16'h0001, 16'hBC00, 16'h0000};
  localparam logic [15:0] REG_RST [NREG] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0C00, 16'h0000};

  // register indices used by the field wiring
  localparam int IX_DAC_BIAS = 0;
  localparam int IX_ADC_OSR = 1;
  localparam int IX_CONVERTER = 8;
  localparam int IX_CLK_DIV = 9;
  localparam int IX_CLK_RATES = 10;
  localparam int IX_STATUS = 11;
  localparam int IX_PAIR_FIRST = 2;
  localparam int NPAIR = 6;

  // field positions
  localparam int BIAS_LSB = 1;
  localparam int OSR_BIT = 0;
  localparam int HALVE_BIT = 0;
  localparam int SRC_BIT = 15;
  localparam int RATE_LSB = 10;
  localparam int ST_RSVD_BIT = 11;
  localparam int ST_UNSUP_BIT = 12;
  localparam int ST_FAM_LSB = 13;

  // decoded values
  localparam int RATIO_W = 11;
  localparam logic [7:0] OSR_LOW = 8'h40;
  localparam logic [7:0] OSR_HIGH = 8'h80;
  localparam logic [6:0] BIAS_PCT [4] = '{7'h64, 7'h32, 7'h42, 7'h4B};
  localparam int NRATE = 10;
  localparam logic [10:0] RATIO_256 [NRATE] = '{11'h040, 11'h080, 11'h0C0, 11'h100,
    11'h180, 11'h200, 11'h300, 11'h400, 11'h580, 11'h600};
  localparam logic [10:0] RATIO_272 [NRATE] = '{11'h044, 11'h088, 11'h0CC, 11'h110,
    11'h198, 11'h220, 11'h330, 11'h440, 11'h5D8, 11'h660};
  localparam logic [10:0] RATIO_250 [NRATE] = '{11'h07D, 11'h07D, 11'h0FA, 11'h0FA,
    11'h177, 11'h1F4, 11'h2EE, 11'h3E8, 11'h3E8, 11'h5DC};

  typedef enum logic [1:0] {
    CPCR_FAM_256 = 2'b00,
    CPCR_FAM_272 = 2'b01,
    CPCR_FAM_250 = 2'b10,
    CPCR_FAM_RSVD = 2'b11
  } cpcr_family_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } cpcr_bus_req_t;

  typedef struct packed {
    logic [1:0] inputAmp;
    logic [1:0] outMixer;
    logic [1:0] headphone;
    logic [1:0] lineOut;
    logic [1:0] spkMixer;
    logic [1:0] spkOut;
    logic [1:0] dac;
    logic [1:0] adc;
  } cpcr_power_t;

endpackage

// *** verilog/cpcr_ratio_decode.sv ***
// clock-to-sample-rate ratio lookup for the selected clock family
`timescale 1ns/1ps
module cpcr_ratio_decode #(
  parameter int RATIO_W = 11
) (
  input cpcr_pkg::cpcr_family_t family,
  input wire logic [3:0] code,
  output logic [RATIO_W-1:0] ratio,
  output logic reserved
);

  // refuse a ratio port too narrow for the largest table entry
  if (RATIO_W < cpcr_pkg::RATIO_W) begin : g_bad_width
    $error("ratio width too small for largest ratio");
  end

  // codes at or beyond the table end are reserved in every family
  wire codeInRange = (code < 4'(cpcr_pkg::NRATE));
  wire [3:0] ix = codeInRange ? code : 4'h0;

  // pick the ratio from the family table
  always_comb begin
    ratio = '0;
    reserved = !codeInRange;
    unique case (family)
      cpcr_pkg::CPCR_FAM_256: ratio = RATIO_W'(cpcr_pkg::RATIO_256[ix]);
      cpcr_pkg::CPCR_FAM_272: ratio = RATIO_W'(cpcr_pkg::RATIO_272[ix]);
      cpcr_pkg::CPCR_FAM_250: ratio = RATIO_W'(cpcr_pkg::RATIO_250[ix]);
      cpcr_pkg::CPCR_FAM_RSVD: reserved = 1'b1;
    endcase
    if (reserved) begin
      ratio = '0;
    end
  end

endmodule // cpcr_ratio_decode

// *** testbench/cpcr_regs_sva.sv ***
// assertion checker for the codec power and clock register bank
`timescale 1ns/1ps
module cpcr_regs_sva #(
  parameter int RATIO_W = 11
) (
  input wire logic clk,
  input wire logic rst,
  input cpcr_pkg::cpcr_bus_req_t busReq,
  input wire logic [15:0] rdata,
  input cpcr_pkg::cpcr_family_t sysclkFamilySelect,
  input cpcr_pkg::cpcr_power_t powerOn,
  input wire logic [1:0] dacRefBufferBias,
  input wire logic [6:0] dacBiasPercent,
  input wire logic adcHighPerfOversample,
  input wire logic [7:0] adcOversampleRatio,
  input wire logic sysclkSourceSelect,
  input wire logic masterClockHalve,
  input wire logic [3:0] sysclkFsRatio,
  input wire logic [RATIO_W-1:0] sysclkRatioValue,
  input wire logic sysclkRatioReserved,
  input wire logic oversampleUnsupported
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // decoded values and bus timing
  osr_ratio_match_a: assert property (adcOversampleRatio == (adcHighPerfOversample ? 8'h80 : 8'h40))
    else $error("oversample ratio does not follow its bit");
  bias_percent_match_a: assert property (dacBiasPercent == (dacRefBufferBias == 2'b00 ? 7'h64 :
    dacRefBufferBias == 2'b01 ? 7'h32 : dacRefBufferBias == 2'b10 ? 7'h42 : 7'h4B))
    else $error("bias percent does not follow its code");
  reserved_zero_ratio_a: assert property (sysclkRatioReserved |-> sysclkRatioValue == '0)
    else $error("reserved ratio code gives nonzero ratio");
  rdata_idle_zero_a: assert property (!busReq.rd |=> rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  input_amp_write_a: assert property ((busReq.wr && busReq.addr == 8'h0C) ##1 !busReq.wr
    |=> powerOn.inputAmp == $past(busReq.wdata[1:0], 2))
    else $error("input amp enables do not follow write");
  converter_readback_a: assert property ((busReq.wr && busReq.addr == 8'h12) ##2 (busReq.rd && busReq.addr == 8'h12)
    |=> rdata == {12'h000, $past(busReq.wdata[3:0], 3)})
    else $error("converter register read back wrong");
  clock_rates_write_a: assert property ((busReq.wr && busReq.addr == 8'h15) ##1 !busReq.wr
    |=> sysclkSourceSelect == $past(busReq.wdata[15], 2) && sysclkFsRatio == $past(busReq.wdata[13:10], 2))
    else $error("clock rate fields do not follow write");
  power_hold_a: assert property (!busReq.wr [*2] |=> $stable(powerOn))
    else $error("power enables changed without a write");
  reserved_seen_c: cover property (sysclkRatioReserved);
  unsupported_seen_c: cover property (oversampleUnsupported);
  readback_seen_c: cover property ((busReq.wr && busReq.addr == 8'h12) ##2 busReq.rd);
endmodule // cpcr_regs_sva

bind cpcr_regs cpcr_regs_sva #(.RATIO_W(RATIO_W)) chk_u (.clk(clk), .rst(rst), .busReq(busReq), .rdata(rdata),
  .sysclkFamilySelect(sysclkFamilySelect), .powerOn(powerOn), .dacRefBufferBias(dacRefBufferBias),
  .dacBiasPercent(dacBiasPercent), .adcHighPerfOversample(adcHighPerfOversample),
  .adcOversampleRatio(adcOversampleRatio), .sysclkSourceSelect(sysclkSourceSelect),
  .masterClockHalve(masterClockHalve), .sysclkFsRatio(sysclkFsRatio), .sysclkRatioValue(sysclkRatioValue),
  .sysclkRatioReserved(sysclkRatioReserved), .oversampleUnsupported(oversampleUnsupported));

// *** testbench/cpcr_regs_test.sv ***
// self-checking testbench for the codec power and clock register bank
`timescale 1ns/1ps
module cpcr_regs_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  cpcr_pkg::cpcr_bus_req_t busReq = '0;
  cpcr_pkg::cpcr_family_t fam = cpcr_pkg::CPCR_FAM_256;
  cpcr_pkg::cpcr_power_t powerOn;
  logic [15:0] rdata;
  logic [1:0] bias;
  logic [6:0] pct;
  logic osrBit, srcSel, halve, rsvd, unsup;
  logic [7:0] osr;
  logic [3:0] rateCode;
  logic [10:0] ratio;
  int failCount = 0;
  int checksDone = 0;
  logic [7:0] ofs [11] = '{8'h08, 8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h14, 8'h15};
  logic [15:0] msk [11] = '{16'h0006, 16'h0001, 16'h0003, 16'h0003, 16'h0003, 16'h0003, 16'h0003,
    16'h0003, 16'h000F, 16'h0001, 16'hBC00};
  logic [15:0] rstv [11] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0C00};
  logic [6:0] pctExp [4] = '{7'h64, 7'h32, 7'h42, 7'h4B};

  cpcr_regs dut_u (.clk(clk), .rst(rst), .busReq(busReq), .rdata(rdata), .sysclkFamilySelect(fam),
    .powerOn(powerOn), .dacRefBufferBias(bias), .dacBiasPercent(pct), .adcHighPerfOversample(osrBit),
    .adcOversampleRatio(osr), .sysclkSourceSelect(srcSel), .masterClockHalve(halve), .sysclkFsRatio(rateCode),
    .sysclkRatioValue(ratio), .sysclkRatioReserved(rsvd), .oversampleUnsupported(unsup));

  // 50 ns clock
  always #25 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    busReq.addr <= a;
    busReq.wdata <= d;
    busReq.wr <= 1'b1;
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the answer cycle
  task automatic rdChk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    busReq.addr <= a;
    busReq.rd <= 1'b1;
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1 check(rdata, exp);
  endtask

  // field outputs lag the register by one edge
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic wrapUp;
    if (failCount == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    wrapUp();
  end

  initial begin
    logic [10:0] expRatio;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    settle();
    for (int i = 0; i < 11; i++) rdChk(ofs[i], rstv[i]);
    check(powerOn, 16'h0000);
    check(osr, 16'h0080);
    check(ratio, 16'h0100);
    check(osrBit, 16'h0001);
    check(rateCode, 16'h0003);
    // status word reads back decoded state and ignores writes
    rdChk(8'h1F, 16'h0100);
    wr(8'h1F, 16'hFFFF);
    rdChk(8'h1F, 16'h0100);
    // unlisted bits dropped, unmapped place reads zero
    for (int i = 0; i < 11; i++) begin
      wr(ofs[i], 16'hFFFF);
      rdChk(ofs[i], msk[i]);
    end
    wr(8'h09, 16'hFFFF);
    rdChk(8'h09, 16'h0000);
    settle();
    check(powerOn, 16'hFFFF);
    check({halve, srcSel}, 16'h0003);
    // left enables only, per pair
    for (int i = 2; i < 9; i++) wr(ofs[i], 16'h000A);
    rdChk(8'h12, 16'h000A);
    settle();
    check(powerOn, 16'hAAAA);
    for (int c = 0; c < 4; c++) begin
      wr(8'h08, 16'(c << 1));
      settle();
      check(bias, 16'(c));
      check(pct, pctExp[c]);
    end
    // low-power oversampling against the 250 and 256 families
    @(posedge clk);
    fam <= cpcr_pkg::CPCR_FAM_250;
    wr(8'h0A, 16'h0000);
    settle();
    check(osr, 16'h0040);
    check(unsup, 16'h0001);
    @(posedge clk);
    fam <= cpcr_pkg::CPCR_FAM_256;
    settle();
    check(unsup, 16'h0000);
    wr(8'h0A, 16'h0001);
    settle();
    check(osr, 16'h0080);
    // every ratio code in every family
    for (int f = 0; f < 4; f++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge clk);
        fam <= cpcr_pkg::cpcr_family_t'(f);
        wr(8'h15, {2'b00, 4'(c), 10'h000});
        settle();
        expRatio = 11'h000;
        if (c < 10 && f == 0) expRatio = cpcr_pkg::RATIO_256[c];
        if (c < 10 && f == 1) expRatio = cpcr_pkg::RATIO_272[c];
        if (c < 10 && f == 2) expRatio = cpcr_pkg::RATIO_250[c];
        check(ratio, expRatio);
        check(rateCode, 16'(c));
        check(rsvd, 16'(f == 3 || c > 9));
      end
    end
    // reset in mid-run restores defaults
    wr(8'h0C, 16'h0003);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdChk(8'h0C, 16'h0000);
    rdChk(8'h15, 16'h0C00);
    check(powerOn, 16'h0000);
    wrapUp();
  end
endmodule // cpcr_regs_test
